// [design/phbi_host.sv]
/*
 * Host end: bus clock generation, slot reset sequencing, round-robin arbiter, clock-run
 * control, parity/system-error monitor and a simple memory target window.
 * Assumes a 200 MHz clock; the bus is sampled on the system edge just before each bus
 * clock rise and host outputs change one system cycle before that rise.
 */
`timescale 1ns/1ps
module phbi_host #(
	parameter logic [31:0] TGT_BASE = 32'h0000_1000,
	parameter int TGT_SPAN_LOG2 = 12,
	parameter int BURST_MAX = 4
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic chip_power_ok_in,
	input wire logic clock_stop_req,
	input wire logic [3:0] clk_alt_sel,
	input wire logic [3:0] clk_alt_val,
	input wire logic [31:0] tgt_rdata,
	output logic tgt_wr,
	output logic tgt_rd,
	output logic [31:0] tgt_addr,
	output logic [31:0] tgt_wdata,
	output logic [3:0] tgt_be,
	output logic parity_err,
	output logic system_err,
	output logic bus_clock_stopped,
	phbi_bus_if.host bus
);
	localparam int HALF = phbi_pkg::BUS_CLK_DIV / 2;
	typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} phbi_tgt_t;
	typedef enum logic [1:0] {CR_RUN, CR_SAY, CR_WATCH, CR_STOP} phbi_crun_t;

	logic chip_power_ok, crun_seen_n;
	logic [2:0] div_cnt;
	logic tick, run_clk, next_clk;
	logic [7:0] rst_cnt;
	logic [3:0] req, gnt, prev_gnt, pick;
	logic owner_used, bus_idle, frame_prev, addr_phase, data_done, hit;
	phbi_tgt_t tstate;
	logic [31:0] addr_q;
	logic is_read, rd_wait;
	logic [3:0] beat, cmd_q;
	logic chk_addr, chk_data, chk_par, par_bad;
	logic [1:0] perr_cnt;
	phbi_crun_t cstate;
	logic [2:0] watch_cnt;

	function automatic logic [3:0] phbi_pick(input logic [3:0] r, input logic [3:0] prev);
		logic [3:0] g;
		int p;
		int k;
		g = 4'h0;
		p = 0;
		for (int i = 0; i < 4; i++) begin
			if (prev[i]) begin
				p = i;
			end
		end
		for (int i = 4; i >= 1; i--) begin
			k = (p + i) % 4;
			if (r[k]) begin
				g = 4'(1 << k);
			end
		end
		return g;
	endfunction

	phbi_sync #(.W(2), .INIT(2'b01)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.ce(ce),
		.d({chip_power_ok_in, bus.clock_run_n}),
		.q({chip_power_ok, crun_seen_n})
	);

	assign tick = ce && div_cnt == 3'(phbi_pkg::BUS_CLK_DIV - 1);
	assign run_clk = cstate != CR_STOP;
	assign next_clk = run_clk && div_cnt < 3'(HALF);
	assign bus_clock_stopped = !run_clk;
	assign req = ~bus.req_n;
	assign bus_idle = bus.frame_n && bus.irdy_n;
	assign addr_phase = !bus.frame_n && frame_prev;
	assign data_done = !bus.irdy_n && !bus.trdy_n;
	assign hit = bus.ad[31:TGT_SPAN_LOG2] == TGT_BASE[31:TGT_SPAN_LOG2]
		&& (bus.cbe == phbi_pkg::CMD_MEM_RD || bus.cbe == phbi_pkg::CMD_MEM_WR);
	assign pick = phbi_pick(req, prev_gnt);
	assign par_bad = bus.par != chk_par;
	assign bus.gnt_n = ~gnt;
	assign bus.serr_o = 1'b0;
	assign bus.perr_oe = perr_cnt != 2'h0;
	assign bus.perr_o = perr_cnt == 2'h1;
	assign bus.crun_h_oe = cstate == CR_RUN || cstate == CR_SAY;
	assign bus.crun_h_o = cstate == CR_SAY;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 3'h0;
		end else if (ce) begin
			div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			bus.bus_clock_out_first <= 1'b0;
			bus.bus_clock_out_alt <= 4'h0;
		end else if (ce) begin
			bus.bus_clock_out_first <= next_clk;
			bus.bus_clock_out_alt <= (clk_alt_sel & clk_alt_val) | (~clk_alt_sel & {4{next_clk}});
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt <= 8'h0;
			bus.slot_reset_n <= 1'b0;
		end else if (ce) begin
			if (!chip_power_ok) begin
				rst_cnt <= 8'h0;
				bus.slot_reset_n <= 1'b0;
			end else if (rst_cnt == 8'(phbi_pkg::RST_HOLD_CYC)) begin
				bus.slot_reset_n <= 1'b1;
			end else begin
				rst_cnt <= rst_cnt + 8'h1;
			end
		end
	end

	// The grant moves only while the bus is idle, so a master never loses it mid-access.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gnt <= 4'h0;
			prev_gnt <= 4'h0;
			owner_used <= 1'b0;
		end else if (ce) begin
			if (!bus.slot_reset_n) begin
				gnt <= 4'h0;
				owner_used <= 1'b0;
			end else if (tick) begin
				if (!bus.frame_n && gnt != 4'h0) begin
					owner_used <= 1'b1;
				end
				if (bus_idle && (owner_used || (gnt & req) == 4'h0)) begin
					gnt <= pick;
					owner_used <= 1'b0;
					if (pick != 4'h0) begin
						prev_gnt <= pick;
					end
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tstate <= T_IDLE;
			bus.tgt_oe <= 1'b0;
			bus.devsel_o <= 1'b1;
			bus.trdy_o <= 1'b1;
			bus.stop_o <= 1'b1;
			bus.ad_h_o <= 32'h0;
			bus.ad_h_oe <= 1'b0;
			addr_q <= 32'h0;
			is_read <= 1'b0;
			rd_wait <= 1'b0;
			beat <= 4'h0;
			tgt_wr <= 1'b0;
			tgt_rd <= 1'b0;
			tgt_addr <= 32'h0;
			tgt_wdata <= 32'h0;
			tgt_be <= 4'h0;
		end else if (ce) begin
			tgt_wr <= 1'b0;
			tgt_rd <= 1'b0;
			if (!bus.slot_reset_n) begin
				tstate <= T_IDLE;
				bus.tgt_oe <= 1'b0;
				bus.ad_h_oe <= 1'b0;
			end else if (tick) begin
				unique case (tstate)
					T_IDLE: begin
						if (addr_phase && hit) begin
							tstate <= T_DATA;
							bus.tgt_oe <= 1'b1;
							bus.devsel_o <= 1'b0;
							bus.stop_o <= 1'b1;
							bus.trdy_o <= !bus.cbe[0];
							is_read <= !bus.cbe[0];
							rd_wait <= !bus.cbe[0];
							tgt_rd <= !bus.cbe[0];
							tgt_addr <= bus.ad;
							addr_q <= bus.ad;
							beat <= 4'h0;
						end
					end
					T_DATA: begin
						if (bus_idle) begin
							tstate <= T_TURN;
							bus.devsel_o <= 1'b1;
							bus.trdy_o <= 1'b1;
							bus.stop_o <= 1'b1;
							bus.ad_h_oe <= 1'b0;
						end else if (rd_wait) begin
							bus.ad_h_o <= tgt_rdata;
							bus.ad_h_oe <= 1'b1;
							bus.trdy_o <= 1'b0;
							rd_wait <= 1'b0;
						end else if (data_done) begin
							beat <= beat + 4'h1;
							addr_q <= addr_q + 32'h4;
							if (!is_read) begin
								tgt_wr <= 1'b1;
								tgt_addr <= addr_q;
								tgt_wdata <= bus.ad;
								tgt_be <= ~bus.cbe;
							end
							// The master samples this phase on the bus clock edge after the tick,
							// so a final phase keeps the claim up and the idle bus releases it.
							if (!bus.frame_n && !bus.stop_n) begin
								tstate <= T_TURN;
								bus.devsel_o <= 1'b1;
								bus.trdy_o <= 1'b1;
								bus.stop_o <= 1'b1;
								bus.ad_h_oe <= 1'b0;
							end else if (!bus.frame_n) begin
								if (beat == 4'(BURST_MAX - 2)) begin
									bus.stop_o <= 1'b0;
								end
								if (is_read) begin
									rd_wait <= 1'b1;
									bus.trdy_o <= 1'b1;
									tgt_rd <= 1'b1;
									tgt_addr <= addr_q + 32'h4;
								end
							end
						end
					end
					T_TURN: begin
						tstate <= T_IDLE;
						bus.tgt_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			frame_prev <= 1'b1;
			chk_addr <= 1'b0;
			chk_data <= 1'b0;
			chk_par <= 1'b0;
			cmd_q <= 4'h0;
			bus.par_h_o <= 1'b0;
			bus.par_h_oe <= 1'b0;
			bus.serr_oe <= 1'b0;
			perr_cnt <= 2'h0;
			parity_err <= 1'b0;
			system_err <= 1'b0;
		end else if (ce) begin
			parity_err <= 1'b0;
			system_err <= 1'b0;
			if (tick) begin
				frame_prev <= bus.frame_n;
				chk_addr <= addr_phase;
				chk_data <= data_done;
				chk_par <= ^{bus.ad, bus.cbe};
				if (addr_phase) begin
					cmd_q <= bus.cbe;
				end
				bus.par_h_o <= ^{bus.ad_h_o, bus.cbe};
				bus.par_h_oe <= bus.ad_h_oe && bus.slot_reset_n;
				bus.serr_oe <= 1'b0;
				if (perr_cnt != 2'h0) begin
					perr_cnt <= perr_cnt - 2'h1;
				end
				if (par_bad && (chk_addr || (chk_data && cmd_q == phbi_pkg::CMD_SPECIAL))) begin
					bus.serr_oe <= 1'b1;
					system_err <= 1'b1;
				end else if (par_bad && chk_data) begin
					perr_cnt <= 2'h2;
					parity_err <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cstate <= CR_RUN;
			watch_cnt <= 3'h0;
		end else if (ce) begin
			if (!bus.slot_reset_n) begin
				cstate <= CR_RUN;
			end else if (tick) begin
				unique case (cstate)
					CR_RUN: begin
						if (clock_stop_req && bus_idle && req == 4'h0 && tstate == T_IDLE) begin
							cstate <= CR_SAY;
						end
					end
					CR_SAY: begin
						cstate <= CR_WATCH;
						watch_cnt <= 3'h0;
					end
					CR_WATCH: begin
						if (!crun_seen_n) begin
							cstate <= CR_RUN;
						end else if (watch_cnt == 3'(phbi_pkg::CLOCK_RUN_N_WATCH - 1)) begin
							cstate <= CR_STOP;
						end else begin
							watch_cnt <= watch_cnt + 3'h1;
						end
					end
					CR_STOP: begin
						if (!crun_seen_n || !clock_stop_req) begin
							cstate <= CR_RUN;
						end
					end
				endcase
			end
		end
	end
endmodule

// [design/phbi_pkg.sv]
/*
 * Shared constants for both ends of the parallel host bus: clock divider, reset hold time,
 * clock-run watch window, master-abort timeout and bus command codes.
 * Assumes a 200 MHz system clock on the host end.
 */
// Overview of operation
// - Release slot reset only after power good.
// - Assert slot reset once power good drops.
// - Clock provider deasserts clock-run before stopping clock.
// - Agent pulling clock-run low keeps clock running.
// - Agents request the bus on active-low requests.
// - One active-low grant per agent, four total.
// - Data parity errors reported except special cycles.
// - System error reports address and special-cycle parity.
// - Master frames each access for its duration.
// - Decoding target claims with device select.
// - Initiator ready required to finish data phase.
// - Target ready shows target can finish phase.
// - Target stop makes master end the transaction.
// - 32-bit address/data, 4-bit command/byte enables.
package phbi_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	// 200 MHz divided by six gives a 33.3 MHz bus clock.
	localparam int BUS_CLK_DIV = 6;
	localparam int RST_HOLD_NS = 1000;
	localparam int RST_HOLD_CYC = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLOCK_RUN_N_WATCH = 4;
	localparam int DEVSEL_TIMEOUT = 5;
	localparam logic [3:0] CMD_SPECIAL = 4'h1;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] REQ_IDLE = 4'hf;
endpackage

// [design/phbi_bus_if.sv]
/*
 * The shared parallel bus between the host end and one agent end.
 * Resolves every two-way and open-drain line from the drivers' output enables; undriven
 * lines read high, as with the board's pull-ups.
 */
`timescale 1ns/1ps
interface phbi_bus_if;
	logic bus_clock_out_first;
	logic [3:0] bus_clock_out_alt;
	logic slot_reset_n;
	logic [3:0] req_n;
	logic [3:0] gnt_n;
	logic [31:0] ad_h_o, ad_a_o, ad;
	logic ad_h_oe, ad_a_oe;
	logic [3:0] cbe_o, cbe;
	logic cbe_oe;
	logic frame_o, frame_oe, frame_n, irdy_o, irdy_oe, irdy_n;
	logic devsel_o, trdy_o, stop_o, tgt_oe, devsel_n, trdy_n, stop_n;
	logic par_h_o, par_h_oe, par_a_o, par_a_oe, par;
	logic perr_o, perr_oe, perr_n, serr_o, serr_oe, serr_n;
	logic crun_h_o, crun_h_oe, crun_a_o, crun_a_oe, clock_run_n;

	assign ad = ad_h_oe ? ad_h_o : (ad_a_oe ? ad_a_o : 32'hffff_ffff);
	assign cbe = cbe_oe ? cbe_o : 4'hf;
	assign frame_n = frame_oe ? frame_o : 1'b1;
	assign irdy_n = irdy_oe ? irdy_o : 1'b1;
	assign devsel_n = tgt_oe ? devsel_o : 1'b1;
	assign trdy_n = tgt_oe ? trdy_o : 1'b1;
	assign stop_n = tgt_oe ? stop_o : 1'b1;
	assign par = par_h_oe ? par_h_o : (par_a_oe ? par_a_o : 1'b1);
	assign perr_n = perr_oe ? perr_o : 1'b1;
	assign serr_n = serr_oe ? serr_o : 1'b1;
	assign clock_run_n = (crun_h_oe ? crun_h_o : 1'b1) & (crun_a_oe ? crun_a_o : 1'b1);

	modport host (
		output bus_clock_out_first, bus_clock_out_alt, slot_reset_n, gnt_n,
		output ad_h_o, ad_h_oe, devsel_o, trdy_o, stop_o, tgt_oe, par_h_o, par_h_oe,
		output perr_o, perr_oe, serr_o, serr_oe, crun_h_o, crun_h_oe,
		input req_n, ad, cbe, frame_n, irdy_n, trdy_n, stop_n, par, clock_run_n
	);
	modport agent (
		output req_n, ad_a_o, ad_a_oe, cbe_o, cbe_oe, frame_o, frame_oe, irdy_o, irdy_oe,
		output par_a_o, par_a_oe, crun_a_o, crun_a_oe,
		input bus_clock_out_first, slot_reset_n, gnt_n, ad, frame_n, irdy_n,
		input devsel_n, trdy_n, stop_n, par
	);
endinterface

// [design/phbi_sync.sv]
/*
 * Three-stage synchroniser; each output bit moves only when stages two and three agree.
 * Assumes inputs are asynchronous to clock.
 */
`timescale 1ns/1ps
module phbi_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1, s2, s3;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
			q <= INIT;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q <= (s2 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
		end
	end
endmodule

// [design/phbi_agent.sv]
/*
 * Agent end: a bus master issuing single-data-phase transfers on the host's bus clock.
 * Assumes it is the only agent on the bus; it drives the whole request vector.
 */
`timescale 1ns/1ps
module phbi_agent #(
	parameter int AGENT_ID = 0
) (
	input wire logic rst_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [3:0] cmd,
	input wire logic [31:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [3:0] be,
	input wire logic keep_clock,
	output logic busy,
	output logic done,
	output logic [31:0] rdata,
	output logic aborted,
	output logic retried,
	output logic parity_err,
	phbi_bus_if.agent bus
);
	typedef enum logic [2:0] {A_IDLE, A_REQ, A_ADDR, A_DATA, A_TURN} phbi_agt_t;

	phbi_agt_t state;
	logic [3:0] cmd_q, be_q;
	logic [31:0] addr_q, wdata_q;
	logic [2:0] wait_cnt;
	logic rd_chk;

	assign busy = state != A_IDLE;
	// Combinational so keep_clock can restart a stopped clock; start acts only on a bus clock edge.
	// hold clock running
	assign bus.crun_a_oe = keep_clock || state != A_IDLE;
	assign bus.crun_a_o = 1'b0;

	always_ff @(posedge bus.bus_clock_out_first or negedge rst_n) begin
		if (!rst_n) begin
			state <= A_IDLE;
			bus.req_n <= phbi_pkg::REQ_IDLE;
			bus.frame_o <= 1'b1;
			bus.frame_oe <= 1'b0;
			bus.irdy_o <= 1'b1;
			bus.irdy_oe <= 1'b0;
			bus.ad_a_o <= 32'h0;
			bus.ad_a_oe <= 1'b0;
			bus.cbe_o <= 4'h0;
			bus.cbe_oe <= 1'b0;
			cmd_q <= 4'h0;
			be_q <= 4'h0;
			addr_q <= 32'h0;
			wdata_q <= 32'h0;
			wait_cnt <= 3'h0;
			rd_chk <= 1'b0;
			done <= 1'b0;
			rdata <= 32'h0;
			aborted <= 1'b0;
			retried <= 1'b0;
			parity_err <= 1'b0;
		end else if (ce) begin
			done <= 1'b0;
			rd_chk <= 1'b0;
			if (rd_chk) begin
				parity_err <= bus.par != ^{rdata, be_q};
			end
			if (!bus.slot_reset_n) begin
				state <= A_IDLE;
				bus.req_n <= phbi_pkg::REQ_IDLE;
				bus.frame_oe <= 1'b0;
				bus.irdy_oe <= 1'b0;
				bus.ad_a_oe <= 1'b0;
				bus.cbe_oe <= 1'b0;
			end else begin
				unique case (state)
					A_IDLE: begin
						if (start) begin
							bus.req_n <= ~(4'h1 << AGENT_ID);
							cmd_q <= cmd;
							be_q <= be;
							addr_q <= addr;
							wdata_q <= wdata;
							aborted <= 1'b0;
							retried <= 1'b0;
							parity_err <= 1'b0;
							state <= A_REQ;
						end
					end
					A_REQ: begin
						if (!bus.gnt_n[AGENT_ID] && bus.frame_n && bus.irdy_n) begin
							bus.frame_o <= 1'b0;
							bus.frame_oe <= 1'b1;
							bus.irdy_o <= 1'b1;
							bus.irdy_oe <= 1'b1;
							bus.ad_a_o <= addr_q;
							bus.ad_a_oe <= 1'b1;
							bus.cbe_o <= cmd_q;
							bus.cbe_oe <= 1'b1;
							state <= A_ADDR;
						end
					end
					A_ADDR: begin
						bus.req_n <= phbi_pkg::REQ_IDLE;
						bus.frame_o <= 1'b1;
						bus.irdy_o <= 1'b0;
						bus.cbe_o <= be_q;
						bus.ad_a_o <= wdata_q;
						bus.ad_a_oe <= cmd_q[0];
						wait_cnt <= 3'h0;
						state <= A_DATA;
					end
					A_DATA: begin
						if ((!bus.trdy_n || !bus.stop_n) && !bus.devsel_n
							|| bus.devsel_n && wait_cnt == 3'(phbi_pkg::DEVSEL_TIMEOUT - 1)) begin
							bus.irdy_o <= 1'b1;
							bus.frame_oe <= 1'b0;
							bus.ad_a_oe <= 1'b0;
							bus.cbe_oe <= 1'b0;
							done <= 1'b1;
							state <= A_TURN;
							if (!bus.trdy_n && !bus.devsel_n) begin
								rdata <= bus.ad;
								rd_chk <= !cmd_q[0];
							end else if (!bus.devsel_n) begin
								retried <= 1'b1;
							end else begin
								aborted <= 1'b1;
							end
						end else if (bus.devsel_n) begin
							wait_cnt <= wait_cnt + 3'h1;
						end
					end
					A_TURN: begin
						bus.irdy_oe <= 1'b0;
						state <= A_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge bus.bus_clock_out_first or negedge rst_n) begin
		if (!rst_n) begin
			bus.par_a_o <= 1'b0;
			bus.par_a_oe <= 1'b0;
		end else if (ce) begin
			bus.par_a_o <= ^{bus.ad_a_o, bus.cbe_o};
			bus.par_a_oe <= bus.ad_a_oe;
		end
	end
endmodule

// [tb/phbi_bus_sva.sv]
/* Checker for the shared host bus: grants, handshakes, error lines and clock-run.
   Assumes the host's system clock and reset, and a bench with no parity faults. */
`timescale 1ns/1ps
module phbi_bus_sva (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic bus_clock_out_first,
	input wire logic [3:0] gnt_n,
	input wire logic frame_n,
	input wire logic irdy_n,
	input wire logic devsel_n,
	input wire logic trdy_n,
	input wire logic stop_n,
	input wire logic perr_n,
	input wire logic serr_n,
	input wire logic clock_run_n
);
	logic prev_bclk;
	logic [3:0] stall_cnt;
	logic [5:0] run_cnt;
	logic [5:0] irdy_cnt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Counters saturate so that long idle spells cannot wrap into false passes.
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_bclk <= 1'b0;
			stall_cnt <= 4'h0;
		end else begin
			prev_bclk <= bus_clock_out_first;
			if (prev_bclk != bus_clock_out_first) stall_cnt <= 4'h0;
			else if (stall_cnt != 4'hf) stall_cnt <= stall_cnt + 4'h1;
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) run_cnt <= 6'h0;
		else if (clock_run_n) run_cnt <= 6'h0;
		else if (run_cnt != 6'h3f) run_cnt <= run_cnt + 6'h1;
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) irdy_cnt <= 6'h0;
		else if (irdy_n) irdy_cnt <= 6'h0;
		else if (irdy_cnt != 6'h3f) irdy_cnt <= irdy_cnt + 6'h1;
	end
	property p_one_grant; $onehot0(~gnt_n); endproperty
	property p_frame_end; $rose(frame_n) |-> !irdy_n; endproperty
	property p_trdy_claimed; !trdy_n |-> !devsel_n; endproperty
	property p_claim_after_addr; $fell(devsel_n) |-> !$past(frame_n); endproperty
	property p_master_ends; (!irdy_n && (!trdy_n || !stop_n)) |-> ##[1:14] irdy_n; endproperty
	property p_irdy_bounded; irdy_cnt < 6'h30; endproperty
	property p_no_alarm; perr_n && serr_n; endproperty
	property p_clock_alive; run_cnt >= 6'h20 |-> stall_cnt < 4'h6; endproperty
	property p_stop_announced; stall_cnt == 4'hc |-> clock_run_n && !bus_clock_out_first;
	endproperty
	a_one_grant: assert property (p_one_grant) else $error("two grants at once");
	a_frame_end: assert property (p_frame_end) else $error("frame ended without irdy");
	a_trdy_claimed: assert property (p_trdy_claimed) else $error("trdy without devsel");
	a_claim_after_addr: assert property (p_claim_after_addr) else $error("bad claim");
	a_master_ends: assert property (p_master_ends) else $error("master kept irdy");
	a_irdy_bounded: assert property (p_irdy_bounded) else $error("data phase hung");
	a_no_alarm: assert property (p_no_alarm) else $error("false parity alarm");
	a_clock_alive: assert property (p_clock_alive) else $error("clock stopped");
	a_stop_announced: assert property (p_stop_announced) else $error("silent stop");
	c_complete: cover property (!irdy_n && !trdy_n);
	c_abort: cover property (irdy_cnt == 6'h18);
	c_stopped: cover property (stall_cnt == 4'hf);
endmodule

// [tb/test_pci_host_bus_interface.sv]
/* Bench joining the host end and one agent end over the shared bus.
   Assumes nothing outside; the bench holds the memory behind the host's target window. */
`timescale 1ns/1ps
module test_pci_host_bus_interface;
	typedef struct {
		logic [3:0] cmd;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0] be;
		logic abort;
		logic [31:0] rdata;
	} phbi_row_t;
	localparam logic [3:0] wr_cmd = phbi_pkg::CMD_MEM_WR;
	localparam logic [3:0] rd_cmd = phbi_pkg::CMD_MEM_RD;
	logic clock, rst_n, power_ok, stop_req, start, keep, alarm, prev_frame, bclk;
	logic tgt_wr, tgt_rd, h_perr, h_serr, stopped, busy, done, aborted, retried, a_perr;
	logic [3:0] alt_sel, alt_val, cmd, be, last_gnt, cap_cbe, tgt_be;
	logic [31:0] addr, wdata, cap_ad, tgt_addr, tgt_wdata, tgt_rdata, rdata;
	logic [31:0] mem [0:1023];
	int n_mismatch, compares, n_wr, n_rd, i, hi;
	phbi_row_t rows [9];
	phbi_bus_if u_phbi_bus_if ();
	phbi_host u_phbi_host (.clock(clock), .rst_n(rst_n), .ce(1'b1),
		.chip_power_ok_in(power_ok), .clock_stop_req(stop_req), .clk_alt_sel(alt_sel),
		.clk_alt_val(alt_val), .tgt_rdata(tgt_rdata), .tgt_wr(tgt_wr), .tgt_rd(tgt_rd),
		.tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .tgt_be(tgt_be), .parity_err(h_perr),
		.system_err(h_serr), .bus_clock_stopped(stopped), .bus(u_phbi_bus_if));
	phbi_agent u_phbi_agent (.rst_n(rst_n), .ce(1'b1), .start(start), .cmd(cmd), .addr(addr),
		.wdata(wdata), .be(be), .keep_clock(keep), .busy(busy), .done(done), .rdata(rdata),
		.aborted(aborted), .retried(retried), .parity_err(a_perr), .bus(u_phbi_bus_if));
	phbi_bus_sva u_phbi_bus_sva (.clock(clock), .rst_n(rst_n), .bus_clock_out_first(bclk),
		.gnt_n(u_phbi_bus_if.gnt_n), .frame_n(u_phbi_bus_if.frame_n),
		.irdy_n(u_phbi_bus_if.irdy_n), .devsel_n(u_phbi_bus_if.devsel_n),
		.trdy_n(u_phbi_bus_if.trdy_n), .stop_n(u_phbi_bus_if.stop_n),
		.perr_n(u_phbi_bus_if.perr_n), .serr_n(u_phbi_bus_if.serr_n),
		.clock_run_n(u_phbi_bus_if.clock_run_n));
	assign bclk = u_phbi_bus_if.bus_clock_out_first;
	assign tgt_rdata = mem[tgt_addr[11:2]];
	// The memory behind the target window and the bus monitor share one process.
	always @(posedge clock) begin
		prev_frame <= u_phbi_bus_if.frame_n;
		if (prev_frame === 1'b1 && u_phbi_bus_if.frame_n === 1'b0) begin
			cap_ad <= u_phbi_bus_if.ad;
			cap_cbe <= u_phbi_bus_if.cbe;
		end
		if (u_phbi_bus_if.gnt_n !== 4'hf) last_gnt <= u_phbi_bus_if.gnt_n;
		if (h_perr !== 1'b0 || h_serr !== 1'b0) alarm <= 1'b1;
		if (tgt_rd === 1'b1) n_rd <= n_rd + 1;
		if (tgt_wr === 1'b1) begin
			n_wr <= n_wr + 1;
			for (int b = 0; b < 4; b++)
				if (tgt_be[b]) mem[tgt_addr[11:2]][8*b +: 8] <= tgt_wdata[8*b +: 8];
		end
	end
	task chk(input logic ok, input string what);
		compares++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t ns: %s", $time, what);
		end
	endtask
	task wrap_up();
		$display("mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// A wait that runs out ends the run, since later steps would only cascade.
	task bail(input logic ok, input string what);
		chk(ok, what);
		if (ok !== 1'b1) wrap_up();
	endtask
	task xfer(input phbi_row_t r);
		int w0;
		int r0;
		int k;
		last_gnt = 4'hf;
		w0 = n_wr;
		r0 = n_rd;
		@(posedge bclk);
		#1;
		cmd = r.cmd;
		addr = r.addr;
		wdata = r.wdata;
		be = r.be;
		start = 1'b1;
		@(posedge bclk);
		#1;
		start = 1'b0;
		for (k = 0; k < 600 && done !== 1'b1; k++) @(posedge clock);
		bail(done === 1'b1, "transfer never completed");
		repeat (2) @(posedge clock);
		chk(last_gnt === 4'he, "grant not on the requester alone");
		chk(cap_ad === r.addr && cap_cbe === r.cmd, "address phase wrong");
		chk(aborted === r.abort && retried === 1'b0, "claim outcome wrong");
		if (r.cmd == rd_cmd && !r.abort) chk(rdata === r.rdata, "read data wrong");
		chk(n_wr - w0 == ((r.cmd == wr_cmd && !r.abort) ? 1 : 0), "write beats wrong");
		chk(n_rd - r0 == ((r.cmd == rd_cmd && !r.abort) ? 1 : 0), "read fetches wrong");
		chk(u_phbi_bus_if.req_n === 4'hf, "request left asserted");
		chk(a_perr === 1'b0, "parity flagged on clean data");
		for (k = 0; k < 100 && busy !== 1'b0; k++) @(posedge clock);
		bail(busy === 1'b0, "agent stays busy");
	endtask
	task power(input logic on);
		int k;
		@(posedge clock);
		#1;
		power_ok = on;
		if (on) begin
			repeat (phbi_pkg::RST_HOLD_CYC - 2) @(posedge clock);
			chk(u_phbi_bus_if.slot_reset_n === 1'b0, "slot reset released early");
			for (k = 0; k < 20 && u_phbi_bus_if.slot_reset_n !== 1'b1; k++) @(posedge clock);
			bail(u_phbi_bus_if.slot_reset_n === 1'b1, "slot reset held");
		end else begin
			for (k = 0; k < 20 && u_phbi_bus_if.slot_reset_n !== 1'b0; k++) @(posedge clock);
			bail(u_phbi_bus_if.slot_reset_n === 1'b0, "slot reset not asserted");
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	initial begin
		{rst_n, power_ok, stop_req, start, keep, alarm, prev_frame} = 7'h01;
		{alt_sel, alt_val, cmd, be} = 16'h0;
		{addr, wdata} = 64'h0;
		n_wr = 0;
		n_rd = 0;
		foreach (mem[j]) mem[j] = 32'h0;
		rows = '{'{wr_cmd, 32'h0000_1000, 32'ha5a5_0001, 4'h0, 1'b0, 32'h0},
			'{wr_cmd, 32'h0000_1004, 32'h1234_5678, 4'h0, 1'b0, 32'h0},
			'{rd_cmd, 32'h0000_1000, 32'h0, 4'h0, 1'b0, 32'ha5a5_0001},
			'{wr_cmd, 32'h0000_1004, 32'hffff_abcd, 4'hc, 1'b0, 32'h0},
			'{rd_cmd, 32'h0000_1004, 32'h0, 4'h0, 1'b0, 32'h1234_abcd},
			'{wr_cmd, 32'h0000_1ffc, 32'h0000_00ff, 4'h0, 1'b0, 32'h0},
			'{rd_cmd, 32'h0000_1ffc, 32'h0, 4'h0, 1'b0, 32'h0000_00ff},
			'{rd_cmd, 32'h0000_2000, 32'h0, 4'h0, 1'b1, 32'h0},
			'{phbi_pkg::CMD_SPECIAL, 32'h0, 32'h0000_0005, 4'h0, 1'b1, 32'h0}};
		repeat (2) @(posedge clock);
		#1;
		rst_n = 1'b1;
		chk(u_phbi_bus_if.gnt_n === 4'hf && u_phbi_bus_if.slot_reset_n === 1'b0, "reset state");
		power(1'b1);
		foreach (rows[k]) xfer(rows[k]);
		@(posedge clock);
		#1;
		alt_sel = 4'h5;
		alt_val = 4'h1;
		hi = 0;
		repeat (3) @(posedge clock);
		for (i = 0; i < 12; i++) begin
			@(negedge clock);
			hi += bclk;
			chk(u_phbi_bus_if.bus_clock_out_alt === {bclk, 1'b0, bclk, 1'b1}, "alternates");
		end
		chk(hi >= 4 && hi <= 8, "first bus clock not running");
		@(posedge clock);
		#1;
		alt_sel = 4'h0;
		keep = 1'b1;
		stop_req = 1'b1;
		repeat (300) @(posedge clock);
		chk(stopped === 1'b0, "clock stopped while held running");
		#1 keep = 1'b0;
		for (i = 0; i < 300 && stopped !== 1'b1; i++) @(posedge clock);
		bail(stopped === 1'b1, "bus clock never stopped");
		chk(bclk === 1'b0 && u_phbi_bus_if.clock_run_n === 1'b1, "stop state wrong");
		#1 keep = 1'b1;
		for (i = 0; i < 60 && stopped !== 1'b0; i++) @(posedge clock);
		bail(stopped === 1'b0, "clock did not restart");
		#1 stop_req = 1'b0;
		keep = 1'b0;
		repeat (60) @(posedge clock);
		power(1'b0);
		power(1'b1);
		xfer(rows[2]);
		chk(alarm === 1'b0, "host raised a parity alarm");
		wrap_up();
	end
endmodule
